// >>> verilog/crs_consts.svh
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH
// Summary of operation
// - wake factor 1 in deep stop moves the chip to cyclic run, or to full run when run wake is set
// - wake factor 0 or 1 in cyclic stop moves the chip to cyclic run
// - cyclic run entry from cyclic stop, or from deep stop with no fast interrupt pending, starts core 0 at lowest standby RAM address
// - fast NMI or fast INT pending on deep stop exit to cyclic run selects handler vector
// - writing 1 to stop trigger in cyclic run enters cyclic stop
// - writing 1 to deep stop trigger in cyclic run enters deep stop
// - return to full run from cyclic run passes through deep stop
// - wake events are recorded in flag registers 0 to 2, one per bank 0 to 2
// - PLL and flash are disabled during cyclic run
// - only core 0 runs in cyclic run, cores 1 to 3 held stopped
// - only LIN, multichannel serial and always-on peripherals active in cyclic run
// - standby RAM accessible in cyclic run, retained in cyclic stop
`define CRS_OFS_FLAG0 12'h000
`define CRS_OFS_FLAG1 12'h004
`define CRS_OFS_FLAG2 12'h008
`define CRS_OFS_CLR0 12'h010
`define CRS_OFS_CLR1 12'h014
`define CRS_OFS_CLR2 12'h018
`define CRS_OFS_MSK0 12'h020
`define CRS_OFS_MSK1 12'h024
`define CRS_OFS_MSK2 12'h028
`define CRS_OFS_STPT 12'h030
`define CRS_OFS_PSC 12'h034
`define CRS_OFS_MODE 12'h038
`define CRS_OFS_RUNWAKE 12'h03c
`define CRS_OFS_IRQ_STAT 12'h040
`define CRS_OFS_IRQ_MASK 12'h044
`define CRS_OFS_VEC 12'h048
`define CRS_MSK_RST 32'hffffffff
`define CRS_STBY_RAM_BASE 32'hfe000000
`define CRS_EXC_BASE 32'hfe800000
`define CRS_FAST_NONMASKABLE_IRQ_OFS 32'h000000e0
`define CRS_FAST_MASKABLE_IRQ_OFS 32'h000000f0
`define CRS_BIT_TRIG 0
`define CRS_IRQ_ENTER 0
`define CRS_IRQ_STOP 1
`define CRS_IRQ_DEEP 2
`define CRS_IRQ_WAKE 3
`endif

// >>> verilog/crs_pkg.sv
package crs_pkg;
   typedef enum logic [2:0] {
      CRS_RUN,
      CRS_DEEP_STOP,
      CRS_CYC_RUN,
      CRS_CYC_STOP
   } crs_mode_t;
endpackage

// >>> verilog/crs_wake_if.sv
`timescale 1ns/1ps
interface crs_wake_if;
   logic [31:0] raw0;
   logic [31:0] raw1;
   logic [31:0] raw2;
   logic [31:0] ev0;
   logic [31:0] ev1;
   logic [31:0] ev2;
   modport sync (input raw0, input raw1, input raw2, output ev0, output ev1, output ev2);
   modport core (output raw0, output raw1, output raw2, input ev0, input ev1, input ev2);
endinterface

// >>> verilog/crs_wake_sync.sv
`timescale 1ns/1ps
module crs_wake_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // signals
   crs_wake_if.sync w
);
   logic [95:0] s1_q;
   logic [95:0] s2_q;
   logic [95:0] s3_q;
   logic [95:0] st_q;
   logic [95:0] raw;
   assign raw = {w.raw2, w.raw1, w.raw0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 96'h0;
         s2_q <= 96'h0;
         s3_q <= 96'h0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // stable level updates when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < 96; i = i + 1) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
               st_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

   // rising edge of the settled level
   logic [95:0] ev;
   assign ev = s3_q & (s2_q & ~st_q);
   assign w.ev0 = ev[31:0];
   assign w.ev1 = ev[63:32];
   assign w.ev2 = ev[95:64];
endmodule

// >>> verilog/crs_irq.sv
`timescale 1ns/1ps
module crs_irq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // events and software access
   input wire logic [3:0] event_in,
   input wire logic [3:0] clr_in,
   input wire logic mask_we,
   input wire logic [3:0] mask_wdata,
   // state
   output logic [3:0] status_q,
   output logic [3:0] mask_q,
   output logic irq
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 4'h0;
      end else begin
         status_q <= (status_q & ~clr_in) | event_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 4'h0;
      end else if (mask_we) begin
         mask_q <= mask_wdata;
      end
   end

   assign irq = |(status_q & mask_q);
endmodule

// >>> verilog/crs_top.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "crs_consts.svh"
module crs_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wake-up sources, asynchronous
   input wire logic [31:0] wake_src0,
   input wire logic [31:0] wake_src1,
   input wire logic [31:0] wake_src2,
   input wire logic fast_nonmaskable_irq,
   input wire logic fast_maskable_irq,
   // mode outputs
   output logic [2:0] mode,
   output logic cpu0_run,
   output logic [2:0] cpu123_run,
   output logic [31:0] cpu0_start_vec,
   output logic cpu0_start,
   output logic pll_en,
   output logic flash_en,
   output logic lin_serial_unit_en,
   output logic multichannel_serial_unit_en,
   output logic always_on_domain_en,
   output logic other_periph_en,
   output logic stby_ram_access_en,
   output logic stby_ram_retain,
   output logic irq
);
   crs_pkg::crs_mode_t mode_q;
   logic [31:0] flag_q [3];
   logic [31:0] mask_q [3];
   logic [31:0] ev [3];
   logic [31:0] clr [3];
   logic [31:0] fired [3];
   logic [31:0] prdata_q;
   logic fast_nonmaskable_irq_q;
   logic fast_maskable_irq_q;
   logic [1:0] fa_s1_q;
   logic [1:0] fa_s2_q;
   logic [1:0] fa_s3_q;
   logic [1:0] fast_st_q;
   logic [31:0] vec_q;
   logic start_q;
   logic run_wake_q;
   logic wr;
   logic rd;
   logic stpt_wr;
   logic psc_wr;
   logic hit;
   logic any0;
   logic any1;
   logic [3:0] irq_ev;
   logic [3:0] irq_clr;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;

   // wake sources through the synchroniser
   crs_wake_if wif ();
   assign wif.raw0 = wake_src0;
   assign wif.raw1 = wake_src1;
   assign wif.raw2 = wake_src2;

   crs_wake_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .w(wif)
   );
   assign ev[0] = wif.ev0;
   assign ev[1] = wif.ev1;
   assign ev[2] = wif.ev2;

   // apb decode, zero wait
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      unique case (paddr)
         `CRS_OFS_FLAG0,
         `CRS_OFS_FLAG1,
         `CRS_OFS_FLAG2,
         `CRS_OFS_CLR0,
         `CRS_OFS_CLR1,
         `CRS_OFS_CLR2,
         `CRS_OFS_MSK0,
         `CRS_OFS_MSK1,
         `CRS_OFS_MSK2,
         `CRS_OFS_STPT,
         `CRS_OFS_PSC,
         `CRS_OFS_MODE,
         `CRS_OFS_RUNWAKE,
         `CRS_OFS_IRQ_STAT,
         `CRS_OFS_IRQ_MASK,
         `CRS_OFS_VEC: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   // unmapped offsets flag an error in the access phase
   assign pslverr = psel & penable & ~hit;
   // trigger writes
   assign stpt_wr = wr & (paddr == `CRS_OFS_STPT) & pwdata[`CRS_BIT_TRIG];
   assign psc_wr = wr & (paddr == `CRS_OFS_PSC) & pwdata[`CRS_BIT_TRIG];

   // flags are sticky, set beats clear, bank write-one-to-clear
   genvar b;
   generate
      for (b = 0; b < 3; b = b + 1) begin : g_bank
         assign clr[b] = (wr && paddr == (`CRS_OFS_CLR0 + 12'(4 * b))) ? pwdata : 32'h0;
         assign fired[b] = ev[b] & ~mask_q[b];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flag_q[b] <= 32'h0;
            end else begin
               flag_q[b] <= (flag_q[b] & ~clr[b]) | fired[b];
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mask_q[b] <= `CRS_MSK_RST;
            end else if (wr && paddr == (`CRS_OFS_MSK0 + 12'(4 * b))) begin
               mask_q[b] <= pwdata;
            end
         end
      end
   endgenerate

   // factor 0 is bit zero of bank 0, factor 1 is any other unmasked source
   assign any0 = fired[0][0];
   assign any1 = |{fired[0][31:1], fired[1], fired[2]};

   // fast interrupts via three flops, latched while in deep stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fa_s1_q <= 2'h0;
         fa_s2_q <= 2'h0;
         fa_s3_q <= 2'h0;
      end else begin
         fa_s1_q <= {fast_maskable_irq, fast_nonmaskable_irq};
         fa_s2_q <= fa_s1_q;
         fa_s3_q <= fa_s2_q;
      end
   end

   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1) begin : g_fast
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               fast_st_q[k] <= 1'b0;
            end else if (fa_s2_q[k] == fa_s3_q[k]) begin
               fast_st_q[k] <= fa_s3_q[k];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_nonmaskable_irq_q <= 1'b0;
         fast_maskable_irq_q <= 1'b0;
      end else if (mode_q != crs_pkg::CRS_DEEP_STOP) begin
         fast_nonmaskable_irq_q <= 1'b0;
         fast_maskable_irq_q <= 1'b0;
      end else begin
         fast_nonmaskable_irq_q <= fast_nonmaskable_irq_q | fast_st_q[0];
         fast_maskable_irq_q <= fast_maskable_irq_q | fast_st_q[1];
      end
   end

   // mode sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= crs_pkg::CRS_RUN;
      end else begin
         unique case (mode_q)
            crs_pkg::CRS_RUN: begin
               if (psc_wr) begin
                  mode_q <= crs_pkg::CRS_DEEP_STOP;
               end
            end
            // only wake factor 1 leaves deep stop
            crs_pkg::CRS_DEEP_STOP: begin
               if (any1 && !run_wake_q) begin
                  mode_q <= crs_pkg::CRS_CYC_RUN;
               end else if (any1 && run_wake_q) begin
                  mode_q <= crs_pkg::CRS_RUN;
               end
            end
            crs_pkg::CRS_CYC_RUN: begin
               if (psc_wr) begin
                  mode_q <= crs_pkg::CRS_DEEP_STOP;
               end else if (stpt_wr) begin
                  mode_q <= crs_pkg::CRS_CYC_STOP;
               end
            end
            crs_pkg::CRS_CYC_STOP: begin
               if (any0 || any1) begin
                  mode_q <= crs_pkg::CRS_CYC_RUN;
               end
            end
            default: mode_q <= crs_pkg::CRS_RUN;
         endcase
      end
   end

   // software selects whether the next deep stop wake returns to full run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_wake_q <= 1'b0;
      end else if (wr && paddr == `CRS_OFS_RUNWAKE) begin
         run_wake_q <= pwdata[0];
      end
   end

   // restart vector and start pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_q <= `CRS_STBY_RAM_BASE;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (mode_q == crs_pkg::CRS_DEEP_STOP && any1 && !run_wake_q) begin
            start_q <= 1'b1;
            if (fast_nonmaskable_irq_q) begin
               vec_q <= `CRS_EXC_BASE + `CRS_FAST_NONMASKABLE_IRQ_OFS;
            end else if (fast_maskable_irq_q) begin
               vec_q <= `CRS_EXC_BASE + `CRS_FAST_MASKABLE_IRQ_OFS;
            end else begin
               vec_q <= `CRS_STBY_RAM_BASE;
            end
         end else if (mode_q == crs_pkg::CRS_CYC_STOP && (any0 || any1)) begin
            start_q <= 1'b1;
            vec_q <= `CRS_STBY_RAM_BASE;
         end
      end
   end

   // status interrupts
   always_comb begin
      irq_ev[`CRS_IRQ_ENTER] = start_q;
      irq_ev[`CRS_IRQ_STOP] = (mode_q == crs_pkg::CRS_CYC_RUN) && stpt_wr && !psc_wr;
      irq_ev[`CRS_IRQ_DEEP] = (mode_q != crs_pkg::CRS_DEEP_STOP) && psc_wr;
      irq_ev[`CRS_IRQ_WAKE] = any0 | any1;
   end
   assign irq_clr = (wr && paddr == `CRS_OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0;
   crs_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(irq_ev),
      .clr_in(irq_clr),
      .mask_we(wr && paddr == `CRS_OFS_IRQ_MASK),
      .mask_wdata(pwdata[3:0]),
      .status_q(irq_stat),
      .mask_q(irq_mask),
      .irq(irq)
   );

   // read data mux, registered in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (rd && !penable) begin
         unique case (paddr)
            `CRS_OFS_FLAG0: prdata_q <= flag_q[0];
            `CRS_OFS_FLAG1: prdata_q <= flag_q[1];
            `CRS_OFS_FLAG2: prdata_q <= flag_q[2];
            `CRS_OFS_MSK0: prdata_q <= mask_q[0];
            `CRS_OFS_MSK1: prdata_q <= mask_q[1];
            `CRS_OFS_MSK2: prdata_q <= mask_q[2];
            `CRS_OFS_MODE: prdata_q <= {29'h0, mode_q};
            `CRS_OFS_RUNWAKE: prdata_q <= {31'h0, run_wake_q};
            `CRS_OFS_IRQ_STAT: prdata_q <= {28'h0, irq_stat};
            `CRS_OFS_IRQ_MASK: prdata_q <= {28'h0, irq_mask};
            `CRS_OFS_VEC: prdata_q <= vec_q;
            default: prdata_q <= 32'h0;
         endcase
      end
   end
   assign prdata = prdata_q;

   // mode outputs
   logic cyc;
   assign cyc = (mode_q == crs_pkg::CRS_CYC_RUN);
   assign mode = mode_q;
   assign cpu0_start_vec = vec_q;
   assign cpu0_start = start_q;
   assign cpu0_run = (mode_q == crs_pkg::CRS_RUN) | cyc;
   assign cpu123_run = {3{mode_q == crs_pkg::CRS_RUN}};
   assign pll_en = (mode_q == crs_pkg::CRS_RUN);
   assign flash_en = (mode_q == crs_pkg::CRS_RUN);
   assign lin_serial_unit_en = (mode_q != crs_pkg::CRS_DEEP_STOP);
   assign multichannel_serial_unit_en = (mode_q == crs_pkg::CRS_RUN) | cyc;
   assign always_on_domain_en = 1'b1;
   assign other_periph_en = (mode_q == crs_pkg::CRS_RUN);
   assign stby_ram_access_en = (mode_q == crs_pkg::CRS_RUN) | cyc;
   assign stby_ram_retain = 1'b1;
endmodule

// >>> bench/crs_top_sva.sv
`timescale 1ns/1ps
module crs_top_sva (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // mode outputs
   input wire logic [2:0] mode,
   input wire logic cpu0_run,
   input wire logic [2:0] cpu123_run,
   input wire logic [31:0] cpu0_start_vec,
   input wire logic cpu0_start,
   input wire logic pll_en,
   input wire logic flash_en,
   input wire logic lin_serial_unit_en,
   input wire logic multichannel_serial_unit_en,
   input wire logic always_on_domain_en,
   input wire logic other_periph_en,
   input wire logic stby_ram_access_en,
   input wire logic stby_ram_retain
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cr;
   logic wr1;
   assign cr = mode == crs_pkg::CRS_CYC_RUN;
   assign wr1 = psel && penable && pwrite && pwdata[0];
   pll_flash_a:
   assert property (cr |-> !pll_en && !flash_en) else $error("pll or flash on in cyclic run");
   core_only0_a:
   assert property (cr |-> cpu0_run && cpu123_run == 3'h0) else $error("wrong cores in cyclic run");
   periph_set_a:
   assert property (cr |-> !other_periph_en && lin_serial_unit_en && multichannel_serial_unit_en
      && always_on_domain_en) else $error("wrong peripherals in cyclic run");
   ram_keep_a:
   assert property ((cr |-> stby_ram_access_en) and (mode == crs_pkg::CRS_CYC_STOP |-> stby_ram_retain))
      else $error("standby ram not kept");
   stop_trig_a:
   assert property (cr && wr1 && paddr == 12'h030 |=> mode == crs_pkg::CRS_CYC_STOP)
      else $error("stop trigger ignored");
   deep_trig_a:
   assert property (cr && wr1 && paddr == 12'h034 |=> mode == crs_pkg::CRS_DEEP_STOP)
      else $error("deep stop trigger ignored");
   no_direct_a:
   assert property ($past(mode) == crs_pkg::CRS_CYC_RUN |-> mode != crs_pkg::CRS_RUN)
      else $error("cyclic run left straight to run");
   deep_exit_a:
   assert property ($past(mode) == crs_pkg::CRS_DEEP_STOP && cr |-> cpu0_start && (cpu0_start_vec == 32'hfe000000
      || cpu0_start_vec == 32'hfe8000e0 || cpu0_start_vec == 32'hfe8000f0)) else $error("bad deep stop exit");
   stop_exit_a:
   assert property ($past(mode) == crs_pkg::CRS_CYC_STOP && cr |-> cpu0_start && cpu0_start_vec == 32'hfe000000)
      else $error("bad cyclic stop exit");
endmodule
bind crs_top crs_top_sva crs_top_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .mode,
   .cpu0_run, .cpu123_run, .cpu0_start_vec, .cpu0_start, .pll_en, .flash_en, .lin_serial_unit_en,
   .multichannel_serial_unit_en, .always_on_domain_en, .other_periph_en, .stby_ram_access_en, .stby_ram_retain);

// >>> bench/crs_wake_model.sv
`timescale 1ns/1ps
module crs_wake_model #(parameter int PERIOD = 40) (
   // control
   input wire logic pclk,
   input wire logic run,
   input wire logic [1:0] bank,
   input wire logic [4:0] bitn,
   // wake sources
   output logic [31:0] wake_src0,
   output logic [31:0] wake_src1,
   output logic [31:0] wake_src2
);
   int cnt_q = 0;
   logic pulse_q = 1'b0;
   // interval timer, periodic wake trigger
   always @(posedge pclk) begin
      cnt_q <= run ? (cnt_q + 1) % PERIOD : 0;
      pulse_q <= run && cnt_q < 8;
   end
   assign {wake_src2, wake_src1, wake_src0} = pulse_q ? 96'h1 << (32 * bank + bitn) : 96'h0;
endmodule

// >>> bench/crs_top_tb_top.sv
`timescale 1ns/1ps
`include "crs_consts.svh"
module crs_top_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, fnmi, fint, run, irq, start, perr, fl, op;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, vec, w0, w1, w2;
   logic [2:0] mode;
   logic [1:0] bank;
   logic [4:0] bitn;
   logic [31:0] rq[$];
   logic [31:0] vq[$];
   logic [31:0] vt[3] = '{32'hfe000000, 32'hfe8000e0, 32'hfe8000f0};
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int b, f;
   crs_top crs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr), .wake_src0(w0),
      .wake_src1(w1), .wake_src2(w2), .fast_nonmaskable_irq(fnmi), .fast_maskable_irq(fint), .mode(mode),
      .cpu0_run(), .cpu123_run(), .cpu0_start_vec(vec), .cpu0_start(start), .pll_en(), .flash_en(fl),
      .lin_serial_unit_en(), .multichannel_serial_unit_en(), .always_on_domain_en(), .other_periph_en(op),
      .stby_ram_access_en(), .stby_ram_retain(), .irq(irq));
   crs_wake_model crs_wake_model_i (.pclk(pclk), .run(run), .bank(bank), .bitn(bitn), .wake_src0(w0),
      .wake_src1(w1), .wake_src2(w2));
   always #5 pclk = ~pclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rq.push_back(e);
      apb(a, 0, 0);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (int i = 0; i < 60 && mode !== m; i++) @(posedge pclk);
      @(negedge pclk);
      check(mode, m, "mode");
   endtask
   task automatic fire(input logic [1:0] bk, input logic [4:0] bt, input logic [2:0] m);
      bank <= bk;
      bitn <= bt;
      run <= 1;
      wait_mode(m);
      @(posedge pclk);
      run <= 0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge pclk);
      check(irq, e, "irq");
   endtask
   // result watcher
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && rq.size() > 0) check(prdata, rq.pop_front(), "prdata");
      if (psel && penable) check(perr, paddr == 12'h04c, "pslverr");
      if (start && mode == crs_pkg::CRS_CYC_RUN) begin
         check(vec, vq.size() > 0 ? vq.pop_front() : 'x, "vector");
         check(fl, 0, "flash enable");
         check(op, 0, "monitors and other peripherals");
      end
      cyc++;
      if (cyc > 5000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, fnmi, fint, run, bank, bitn, paddr, pwdata} = '0;
      void'($urandom(7));
      b = 1 + $urandom % 31;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rd(`CRS_OFS_MSK0, 32'hffffffff);
      rd(`CRS_OFS_VEC, 32'hfe000000);
      rd(`CRS_OFS_IRQ_MASK, 32'h0);
      rd(12'h04c, 32'h0);
      wr(`CRS_OFS_MSK0, 32'hfffffffe);
      wr(`CRS_OFS_MSK1, ~(32'h1 << b));
      wr(`CRS_OFS_IRQ_MASK, 32'hf);
      wr(`CRS_OFS_PSC, 32'h1);
      wait_mode(crs_pkg::CRS_DEEP_STOP);
      vq.push_back(32'hfe000000);
      fire(2'h1, b[4:0], crs_pkg::CRS_CYC_RUN);
      rd(`CRS_OFS_FLAG1, 32'h1 << b);
      rd(`CRS_OFS_IRQ_STAT, 32'hd);
      chk_irq(1);
      wr(`CRS_OFS_IRQ_MASK, 32'h0);
      chk_irq(0);
      wr(`CRS_OFS_IRQ_MASK, 32'hf);
      wr(`CRS_OFS_IRQ_STAT, 32'hf);
      chk_irq(0);
      wr(`CRS_OFS_CLR1, 32'h0);
      rd(`CRS_OFS_FLAG1, 32'h1 << b);
      wr(`CRS_OFS_CLR1, 32'h1 << b);
      rd(`CRS_OFS_FLAG1, 32'h0);
      for (f = 0; f < 2; f++) begin
         wr(`CRS_OFS_STPT, 32'h1);
         wait_mode(crs_pkg::CRS_CYC_STOP);
         vq.push_back(32'hfe000000);
         fire(f[1:0], f ? b[4:0] : 5'h0, crs_pkg::CRS_CYC_RUN);
         wr(`CRS_OFS_CLR0, 32'hffffffff);
         wr(`CRS_OFS_CLR1, 32'hffffffff);
      end
      for (f = 0; f < 3; f++) begin
         wr(`CRS_OFS_PSC, 32'h1);
         wait_mode(crs_pkg::CRS_DEEP_STOP);
         fnmi <= f == 1;
         fint <= f > 0;
         repeat (8) @(posedge pclk);
         vq.push_back(vt[f]);
         fire(2'h1, b[4:0], crs_pkg::CRS_CYC_RUN);
         fnmi <= 0;
         fint <= 0;
         wr(`CRS_OFS_CLR1, 32'hffffffff);
      end
      wr(`CRS_OFS_RUNWAKE, 32'h1);
      wr(`CRS_OFS_PSC, 32'h1);
      wait_mode(crs_pkg::CRS_DEEP_STOP);
      fire(2'h1, b[4:0], crs_pkg::CRS_RUN);
      check(vq.size(), 0, "pending vectors");
      results();
   end
endmodule
